// [hw/chd_pkg.sv]
// Package with constants and carrier types for the card host transfer decode.
package chd_pkg;

   localparam int          DATA_W          = 16;
   localparam int          BYTE_W          = 8;
   localparam int          ADDR_W          = 11;
   localparam int          CLK_MHZ         = 250;
   localparam int          MODE_LOW_US     = 1000;
   localparam int          MODE_LOW_CYC    = MODE_LOW_US * CLK_MHZ;
   localparam int          WAIT_CYC        = 4;
   localparam logic [2:0]  TF_DATA_ADDR    = 3'h0;
   localparam logic [2:0]  CTL_DEVCTL_ADDR = 3'h6;
   localparam logic [2:0]  CTL_DRVADR_ADDR = 3'h7;
   localparam int          BUF_DEPTH       = 2;

   typedef enum logic [1:0]
   {
      CHD_MODE_PCCARD,
      CHD_MODE_IDE
   } chd_mode_t;

   // Host pins after synchronising; every one but addr is active low.
   typedef struct packed
   {
      logic              low_byte_card_enable_n;
      logic              high_byte_card_enable_n;
      logic              reg_select_n;
      logic              io_read_strobe_n;
      logic              io_write_strobe_n;
      logic              mem_read_strobe_n;
      logic              mem_write_strobe_n;
      logic              command_block_select_n;
      logic              control_block_select_n;
      logic              dma_acknowledge_n;
      logic [ADDR_W-1:0] addr;
   } chd_pins_t;

   // One decoded transfer toward the core.
   typedef struct packed
   {
      logic              write;
      logic              is_io;
      logic              is_ctl;
      logic              is_dma;
      logic [1:0]        lanes;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } chd_xfer_t;

endpackage : chd_pkg

// [hw/chd_buf.sv]
// Two-entry valid/ready buffer for decoded transfers.
`timescale 1ns/1ps
module chd_buf
(
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire chd_pkg::chd_xfer_t in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output chd_pkg::chd_xfer_t    out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);

   chd_pkg::chd_xfer_t mem_r [chd_pkg::BUF_DEPTH];
   chd_pkg::chd_xfer_t mem_nxt [chd_pkg::BUF_DEPTH];
   logic [1:0]         cnt_r;
   logic [1:0]         cnt_nxt;
   logic               wp_r;
   logic               wp_nxt;
   logic               rp_r;
   logic               rp_nxt;
   logic               push;
   logic               pop;

   always_comb
   begin
      push     = in_valid && (cnt_r != 2'h2);
      pop      = out_ready && (cnt_r != 2'h0);
      mem_nxt  = mem_r;
      wp_nxt   = wp_r;
      rp_nxt   = rp_r;
      cnt_nxt  = cnt_r;
      if (push)
      begin
         mem_nxt[wp_r] = in_data;
         wp_nxt        = ~wp_r;
      end
      if (pop)
      begin
         rp_nxt = ~rp_r;
      end
      cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cnt_r <= 2'h0;
         wp_r  <= 1'b0;
         rp_r  <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
      end
      mem_r <= mem_nxt;
   end

   assign in_ready  = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data  = mem_r[rp_r];

endmodule : chd_buf

// [hw/chd_decode.sv]
// Host port decode: lane steering, 16-bit acknowledge, cycle extend and mode selection.
`timescale 1ns/1ps
module chd_decode
#(
   parameter int MODE_LOW_CYC = chd_pkg::MODE_LOW_CYC
)
(
   input  wire logic                          clk,
   input  wire logic                          reset,
   input  wire logic                          low_byte_card_enable_n,
   input  wire logic                          high_byte_card_enable_n,
   input  wire logic                          reg_select_n,
   input  wire logic                          io_read_strobe_n,
   input  wire logic                          io_write_strobe_n,
   input  wire logic                          mem_read_strobe_n,
   input  wire logic                          command_block_select_n,
   input  wire logic                          control_block_select_n,
   input  wire logic                          dma_acknowledge_n,
   input  wire logic                          mem_write_strobe_n,
   input  wire logic [chd_pkg::ADDR_W-1:0]    addr,
   input  wire logic [chd_pkg::DATA_W-1:0]    data_in,
   output logic      [chd_pkg::DATA_W-1:0]    data_out,
   output logic      [1:0]                    data_oe,
   output logic                               sixteen_bit_port_ack_n,
   output logic                               wait_n,
   output logic                               ide_mode,
   output chd_pkg::chd_xfer_t                 core_xfer,
   output logic                               core_valid,
   input  wire logic                          core_ready,
   input  wire logic [chd_pkg::DATA_W-1:0]    core_rdata,
   input  wire logic                          core_rdata_valid
);

   // Two-stage synchronisers for every host pin; only stage two is read.
   chd_pkg::chd_pins_t pins_raw;
   chd_pkg::chd_pins_t pins_s1_r;
   chd_pkg::chd_pins_t pins_s2_r;
   logic [chd_pkg::DATA_W-1:0] din_s1_r;
   logic [chd_pkg::DATA_W-1:0] din_s2_r;

   always_comb
   begin
      pins_raw.low_byte_card_enable_n  = low_byte_card_enable_n;
      pins_raw.high_byte_card_enable_n = high_byte_card_enable_n;
      pins_raw.reg_select_n            = reg_select_n;
      pins_raw.io_read_strobe_n        = io_read_strobe_n;
      pins_raw.io_write_strobe_n       = io_write_strobe_n;
      pins_raw.mem_read_strobe_n       = mem_read_strobe_n;
      pins_raw.mem_write_strobe_n      = mem_write_strobe_n;
      pins_raw.command_block_select_n  = command_block_select_n;
      pins_raw.control_block_select_n  = control_block_select_n;
      pins_raw.dma_acknowledge_n       = dma_acknowledge_n;
      pins_raw.addr                    = addr;
   end

   always_ff @(posedge clk)
   begin
      pins_s1_r <= pins_raw;
      pins_s2_r <= pins_s1_r;
      din_s1_r  <= data_in;
      din_s2_r  <= din_s1_r;
   end

   chd_pkg::chd_pins_t p;
   assign p = pins_s2_r;

   // Mode selection state. The mode select shares the memory read strobe pin.
   chd_pkg::chd_mode_t mode_r;
   chd_pkg::chd_mode_t mode_nxt;
   logic               decided_r;
   logic               decided_nxt;
   logic [31:0]        low_cnt_r;
   logic [31:0]        low_cnt_nxt;

   always_comb
   begin
      mode_nxt       = mode_r;
      decided_nxt    = decided_r;
      low_cnt_nxt    = low_cnt_r;
      // Sample mode select once after each reset.
      if (!decided_r)
      begin
         mode_nxt    = p.mem_read_strobe_n ? chd_pkg::CHD_MODE_PCCARD : chd_pkg::CHD_MODE_IDE;
         decided_nxt = 1'b1;
      end
      else if (p.mem_read_strobe_n)
      begin
         mode_nxt    = chd_pkg::CHD_MODE_PCCARD;
         low_cnt_nxt = 32'h0;
      end
      else
      begin
         if (low_cnt_r >= 32'(MODE_LOW_CYC - 1))
         begin
            mode_nxt = chd_pkg::CHD_MODE_IDE;
         end
         else
         begin
            low_cnt_nxt = low_cnt_r + 32'h1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         mode_r    <= chd_pkg::CHD_MODE_PCCARD;
         decided_r <= 1'b0;
         low_cnt_r <= 32'h0;
      end
      else
      begin
         mode_r    <= mode_nxt;
         decided_r <= decided_nxt;
         low_cnt_r <= low_cnt_nxt;
      end
   end

   // Access decode.
   logic                       rd;
   logic                       wr;
   logic                       active;
   logic                       ide;
   logic [1:0]                 lanes;
   logic                       odd_low;
   logic                       is_ctl;
   logic                       is_dma;
   logic                       is_io;

   always_comb
   begin
      ide     = (mode_r == chd_pkg::CHD_MODE_IDE);
      rd      = 1'b0;
      wr      = 1'b0;
      lanes   = 2'b00;
      odd_low = 1'b0;
      is_ctl  = 1'b0;
      is_dma  = 1'b0;
      is_io   = 1'b0;
      if (ide)
      begin
         rd    = !p.io_read_strobe_n;
         wr    = !p.io_write_strobe_n;
         is_io = 1'b1;
         // Illegal select combinations are left undecoded.
         if (!p.command_block_select_n && p.control_block_select_n && p.dma_acknowledge_n)
         begin
            // Data at zero is a word, task file bytes otherwise.
            lanes = (p.addr[2:0] == chd_pkg::TF_DATA_ADDR) ? 2'b11 : 2'b01;
         end
         else if (!p.control_block_select_n && p.command_block_select_n && p.dma_acknowledge_n)
         begin
            // Control block uses the low lane only.
            if (p.addr[2:0] == chd_pkg::CTL_DEVCTL_ADDR
                || (p.addr[2:0] == chd_pkg::CTL_DRVADR_ADDR && rd))
            begin
               lanes = 2'b01;
            end
            is_ctl = 1'b1;
         end
         else if (p.command_block_select_n && p.control_block_select_n && !p.dma_acknowledge_n)
         begin
            lanes  = 2'b11;
            is_dma = 1'b1;
         end
      end
      else if (!(p.low_byte_card_enable_n && p.high_byte_card_enable_n))
      begin
         if (!p.reg_select_n)
         begin
            // I/O strobes count only with register select low.
            rd    = !p.io_read_strobe_n;
            wr    = !p.io_write_strobe_n;
            is_io = 1'b1;
         end
         else
         begin
            // Common memory uses the memory strobes.
            rd = !p.mem_read_strobe_n;
            wr = !p.mem_write_strobe_n;
         end
         if (!p.low_byte_card_enable_n && !p.high_byte_card_enable_n)
         begin
            lanes = 2'b11;
         end
         else if (p.low_byte_card_enable_n)
         begin
            lanes = 2'b10;
         end
         else
         begin
            // A0 picks even or odd byte on low lane.
            lanes   = 2'b01;
            odd_low = p.addr[0];
         end
      end
      active = (rd || wr) && (lanes != 2'b00);
   end

   // Edge detect; a push refused by a full buffer stays pending, so no word is lost.
   logic act_prev_r;
   logic act_prev_nxt;
   logic start;
   logic buf_in_ready;

   always_comb
   begin
      act_prev_nxt = active && (act_prev_r || buf_in_ready);
      start        = active && !act_prev_r;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         act_prev_r <= 1'b0;
      end
      else
      begin
         act_prev_r <= act_prev_nxt;
      end
   end

   // Transfers queue in the two-entry buffer; a full buffer extends the cycle.
   chd_pkg::chd_xfer_t xfer;

   always_comb
   begin
      xfer.write  = wr;
      xfer.is_io  = is_io;
      xfer.is_ctl = is_ctl;
      xfer.is_dma = is_dma;
      xfer.lanes  = lanes;
      xfer.addr   = p.addr;
      xfer.data   = odd_low ? {din_s2_r[7:0], din_s2_r[7:0]} : din_s2_r;
   end

   chd_buf u_buf
   (
      .clk       (clk),
      .reset     (reset),
      .in_data   (xfer),
      .in_valid  (start),
      .in_ready  (buf_in_ready),
      .out_data  (core_xfer),
      .out_valid (core_valid),
      .out_ready (core_ready)
   );

   // Output pins, all registered.
   logic [chd_pkg::DATA_W-1:0] dout_r;
   logic [chd_pkg::DATA_W-1:0] dout_nxt;
   logic [1:0]                 oe_r;
   logic [1:0]                 oe_nxt;
   logic                       ack_n_r;
   logic                       ack_n_nxt;
   logic                       wait_n_r;
   logic                       wait_n_nxt;
   logic                       have_r;
   logic                       have_nxt;
   logic                       ide_r;
   logic                       ide_nxt;

   always_comb
   begin
      // Acknowledge only while a 16-bit capable port is decoded.
      ack_n_nxt = !(is_io && lanes != 2'b00 && !is_ctl
                    && !(ide && lanes == 2'b01));
      have_nxt  = rd ? (have_r || core_rdata_valid) : 1'b0;
      // Hold a read cycle until data arrives, and any new cycle until the buffer frees.
      wait_n_nxt = !((rd && lanes != 2'b00 && !have_nxt) || (start && !buf_in_ready));
      dout_nxt  = dout_r;
      if (core_rdata_valid)
      begin
         dout_nxt = odd_low ? {8'h00, core_rdata[15:8]} : core_rdata;
      end
      // Drive only on decoded reads; low lane floats on high-only reads.
      oe_nxt = (rd && have_nxt) ? lanes : 2'b00;
      ide_nxt = (mode_nxt == chd_pkg::CHD_MODE_IDE);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         dout_r   <= 16'h0000;
         oe_r     <= 2'b00;
         ack_n_r  <= 1'b1;
         wait_n_r <= 1'b1;
         have_r   <= 1'b0;
         ide_r    <= 1'b0;
      end
      else
      begin
         dout_r   <= dout_nxt;
         oe_r     <= oe_nxt;
         ack_n_r  <= ack_n_nxt;
         wait_n_r <= wait_n_nxt;
         have_r   <= have_nxt;
         ide_r    <= ide_nxt;
      end
   end

   assign data_out               = dout_r;
   assign data_oe                = oe_r;
   assign sixteen_bit_port_ack_n = ack_n_r;
   assign wait_n                 = wait_n_r;
   assign ide_mode               = ide_r;

endmodule : chd_decode

// [verif/chd_decode_monitor.sv]
// Port checker for the card host transfer decode.
`timescale 1ns/1ps
module chd_decode_monitor
#(
   parameter int MODE_LOW_CYC = 16
)
(
   input wire logic                       clk,
   input wire logic                       reset,
   input wire logic                       low_byte_card_enable_n,
   input wire logic                       high_byte_card_enable_n,
   input wire logic                       reg_select_n,
   input wire logic                       io_read_strobe_n,
   input wire logic                       mem_read_strobe_n,
   input wire logic                       mem_write_strobe_n,
   input wire logic                       command_block_select_n,
   input wire logic                       control_block_select_n,
   input wire logic                       dma_acknowledge_n,
   input wire logic [chd_pkg::ADDR_W-1:0] addr,
   input wire logic [1:0]                 data_oe,
   input wire logic                       sixteen_bit_port_ack_n,
   input wire logic                       wait_n,
   input wire logic                       ide_mode
);
   logic [15:0] low_cnt_r;
   logic [15:0] low_cnt_nxt;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // Saturates so a long low level never wraps back under the limit.
   always_comb
   begin
      low_cnt_nxt = mem_read_strobe_n ? 16'h0000 : ((&low_cnt_r) ? low_cnt_r : low_cnt_r + 16'h0001);
   end
   always_ff @(posedge clk)
   begin
      low_cnt_r <= reset ? 16'h0000 : low_cnt_nxt;
   end
   sequence s_stby;
      (low_byte_card_enable_n && high_byte_card_enable_n && !ide_mode)[*4];
   endsequence
   sequence s_io_rd;
      (!ide_mode && !reg_select_n && !io_read_strobe_n && !(low_byte_card_enable_n && high_byte_card_enable_n))[*4];
   endsequence
   property p_stby;
      s_stby |=> data_oe == 2'b00;
   endproperty
   property p_inhibit;
      (!ide_mode && reg_select_n && mem_read_strobe_n && mem_write_strobe_n)[*4] |=> data_oe == 2'b00;
   endproperty
   property p_ack_on;
      s_io_rd |=> !sixteen_bit_port_ack_n;
   endproperty
   property p_ack_off;
      s_stby |=> sixteen_bit_port_ack_n;
   endproperty
   property p_high_only;
      (!ide_mode && low_byte_card_enable_n && !high_byte_card_enable_n)[*4] |=> !data_oe[0];
   endproperty
   property p_wait_bound;
      $fell(wait_n) |-> ##[1:300] wait_n;
   endproperty
   property p_task;
      (ide_mode && !command_block_select_n && control_block_select_n && dma_acknowledge_n
       && addr[2:0] != 3'h0)[*4] |=> !data_oe[1];
   endproperty
   property p_ctl;
      (ide_mode && command_block_select_n && !control_block_select_n && dma_acknowledge_n)[*4] |=> !data_oe[1];
   endproperty
   property p_ide_idle;
      (ide_mode && command_block_select_n && control_block_select_n && dma_acknowledge_n)[*4] |=> data_oe == 2'b00;
   endproperty
   property p_mode_pc;
      mem_read_strobe_n[*4] |=> !ide_mode;
   endproperty
   property p_mode_long;
      low_cnt_r == 16'(MODE_LOW_CYC + 6) |-> ide_mode;
   endproperty
   a_stby: assert property (p_stby) else $error("lanes driven in standby");
   a_inhibit: assert property (p_inhibit) else $error("lanes driven while inhibited");
   a_ack_on: assert property (p_ack_on) else $error("no 16-bit ack on decoded port");
   a_ack_off: assert property (p_ack_off) else $error("16-bit ack in standby");
   a_high_only: assert property (p_high_only) else $error("low lane driven on high-only access");
   a_wait_bound: assert property (p_wait_bound) else $error("cycle extension never ends");
   a_task: assert property (p_task) else $error("upper lane on task file access");
   a_ctl: assert property (p_ctl) else $error("upper lane on control block access");
   a_ide_idle: assert property (p_ide_idle) else $error("bus driven while idle");
   a_mode_pc: assert property (p_mode_pc) else $error("mode stays after select high");
   a_mode_long: assert property (p_mode_long) else $error("no mode change after long low");
endmodule : chd_decode_monitor

bind chd_decode chd_decode_monitor #(.MODE_LOW_CYC(MODE_LOW_CYC)) i_mon
(
   .clk(clk), .reset(reset), .low_byte_card_enable_n(low_byte_card_enable_n),
   .high_byte_card_enable_n(high_byte_card_enable_n), .reg_select_n(reg_select_n),
   .io_read_strobe_n(io_read_strobe_n), .mem_read_strobe_n(mem_read_strobe_n),
   .mem_write_strobe_n(mem_write_strobe_n), .command_block_select_n(command_block_select_n),
   .control_block_select_n(control_block_select_n), .dma_acknowledge_n(dma_acknowledge_n), .addr(addr),
   .data_oe(data_oe), .sixteen_bit_port_ack_n(sixteen_bit_port_ack_n), .wait_n(wait_n), .ide_mode(ide_mode)
);

// [verif/chd_host_model.sv]
// Host bus controller model that drives the card pins.
`timescale 1ns/1ps
module chd_host_model
(
   input  wire logic          clk,
   input  wire logic          wait_n,
   input  wire logic          ack_n,
   input  wire logic [15:0]   data_out,
   input  wire logic [1:0]    data_oe,
   output chd_pkg::chd_pins_t pins,
   output logic [15:0]        wdata
);
   chd_pkg::chd_pins_t idle;
   initial
   begin
      idle  = '1;
      pins  = '1;
      wdata = 16'h0000;
   end
   task automatic mode_pin(input logic m);
      @(negedge clk);
      idle.mem_read_strobe_n = m;
      pins = idle;
   endtask : mode_pin
   task automatic xfer(input chd_pkg::chd_pins_t p, input logic [15:0] d, output logic [15:0] q,
                       output logic [1:0] oe, output logic ack);
      int n = 0;
      p.control_block_select_n |= ~p.command_block_select_n;
      @(negedge clk);
      pins  = p;
      wdata = d;
      repeat (5) @(negedge clk);
      while (wait_n !== 1'b1 && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      q    = data_out;
      oe   = data_oe;
      ack  = ack_n;
      pins = idle;
      // A released bus shows the inverse so a stale value cannot pass.
      wdata = ~d;
      repeat (4) @(negedge clk);
   endtask : xfer
   task automatic word(input chd_pkg::chd_pins_t p, input logic [15:0] d, output logic [15:0] q,
                       output logic [1:0] oe, output logic ack);
      logic [15:0] q1;
      xfer(p, d, q, oe, ack);
      if (ack === 1'b1 && !p.reg_select_n && !p.low_byte_card_enable_n && !p.high_byte_card_enable_n)
      begin
         p.high_byte_card_enable_n = 1'b1;
         p.addr[0] = 1'b0;
         xfer(p, d, q1, oe, ack);
         p.addr[0] = 1'b1;
         xfer(p, {8'h00, d[15:8]}, q, oe, ack);
         q = {q[7:0], q1[7:0]};
      end
   endtask : word
endmodule : chd_host_model

// [verif/card_host_transfer_decode_tb.sv]
// Self-checking bench for the card host transfer decode.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
   $display("Error at %0t: got %h, expected %h", $time, (a), (b)); end end
module card_host_transfer_decode_tb;
   localparam int LOWC = 40;
   logic               clk, reset, stall, core_ready, core_rdata_valid, ack_n, wait_n, ide_mode, core_valid, ack;
   logic [15:0]        wd, data_out, q;
   logic [1:0]         data_oe, oe;
   int                 err_count, checks, rcnt;
   chd_pkg::chd_pins_t pins, p;
   chd_pkg::chd_xfer_t core_xfer;
   chd_pkg::chd_xfer_t got[$];
   chd_decode #(.MODE_LOW_CYC(LOWC)) i_dut
   (
      .clk(clk), .reset(reset), .addr(pins.addr), .data_in(wd), .data_out(data_out), .data_oe(data_oe),
      .low_byte_card_enable_n(pins.low_byte_card_enable_n), .high_byte_card_enable_n(pins.high_byte_card_enable_n),
      .reg_select_n(pins.reg_select_n), .io_read_strobe_n(pins.io_read_strobe_n),
      .io_write_strobe_n(pins.io_write_strobe_n), .mem_read_strobe_n(pins.mem_read_strobe_n),
      .mem_write_strobe_n(pins.mem_write_strobe_n), .command_block_select_n(pins.command_block_select_n),
      .control_block_select_n(pins.control_block_select_n), .dma_acknowledge_n(pins.dma_acknowledge_n),
      .sixteen_bit_port_ack_n(ack_n), .wait_n(wait_n), .ide_mode(ide_mode), .core_xfer(core_xfer),
      .core_valid(core_valid), .core_ready(core_ready), .core_rdata(16'hB6C3), .core_rdata_valid(core_rdata_valid)
   );
   chd_host_model i_host
   (
      .clk(clk), .wait_n(wait_n), .ack_n(ack_n), .data_out(data_out), .data_oe(data_oe), .pins(pins), .wdata(wd)
   );
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Core side: takes transfers unless stalled and answers reads three cycles later.
   always @(negedge clk)
   begin
      core_ready       <= ~stall;
      core_rdata_valid <= (rcnt == 1);
      if (rcnt > 0)
         rcnt <= rcnt - 1;
      if (core_valid && !stall && !reset)
      begin
         got.push_back(core_xfer);
         if (!core_xfer.write)
            rcnt <= 3;
      end
   end
   task automatic run(input logic [7:0] s, input logic [2:0] a, input logic [1:0] eo, input logic [15:0] m,
                      input logic [15:0] ed);
      p = i_host.idle;
      {p.reg_select_n, p.high_byte_card_enable_n, p.low_byte_card_enable_n, p.io_read_strobe_n,
       p.mem_read_strobe_n, p.command_block_select_n, p.control_block_select_n, p.dma_acknowledge_n} = s;
      p.addr = 11'(a);
      i_host.word(p, 16'h0000, q, oe, ack);
      `CHK(oe, eo)
      `CHK(q & m, ed & m)
      if (!s[7] && s[6:5] != 2'b11)
         `CHK(ack, 1'b0)
      if (s[6:5] == 2'b11 && !ide_mode)
         `CHK(ack, 1'b1)
   endtask : run
   task automatic t_pc;
      got.delete();
      run(8'h4F, 3'h0, 2'b01, 16'h00FF, 16'h00C3);
      run(8'h4F, 3'h1, 2'b01, 16'h00FF, 16'h00B6);
      run(8'h0F, 3'h0, 2'b11, 16'hFFFF, 16'hB6C3);
      run(8'h2F, 3'h1, 2'b10, 16'hFF00, 16'hB600);
      run(8'h8F, 3'h0, 2'b00, 16'h0000, 16'h0000);
      run(8'h6F, 3'h0, 2'b00, 16'h0000, 16'h0000);
      run(8'hD7, 3'h0, 2'b01, 16'h00FF, 16'h00C3);
      run(8'hD7, 3'h1, 2'b01, 16'h00FF, 16'h00B6);
      run(8'h97, 3'h1, 2'b11, 16'hFFFF, 16'hB6C3);
      run(8'hB7, 3'h0, 2'b10, 16'hFF00, 16'hB600);
      `CHK(got.size(), 8)
      $display("t_pc done");
   endtask : t_pc
   task automatic t_write;
      p = i_host.idle;
      p.addr = 11'h000;
      {p.reg_select_n, p.high_byte_card_enable_n, p.low_byte_card_enable_n, p.io_write_strobe_n} = 4'h0;
      got.delete();
      i_host.word(p, 16'h1E2D, q, oe, ack);
      `CHK(ack, 1'b0)
      `CHK({got[0].write, got[0].lanes, got[0].data}, {3'b111, 16'h1E2D})
      $display("t_write done");
   endtask : t_write
   task automatic t_buf;
      got.delete();
      stall = 1'b1;
      fork
         for (int i = 1; i < 5; i++)
            i_host.word(p, 16'(16'h1111 * i), q, oe, ack);
         begin
            repeat (70) @(negedge clk);
            `CHK(wait_n, 1'b0)
            stall = 1'b0;
         end
      join
      `CHK(got.size(), 4)
      for (int i = 0; i < 4; i++)
         `CHK(got[i].data, 16'(16'h1111 * (i + 1)))
      $display("t_buf done");
   endtask : t_buf
   task automatic t_ide;
      i_host.mode_pin(1'b0);
      reset = 1'b1;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      repeat (6) @(negedge clk);
      `CHK(ide_mode, 1'b1)
      run(8'hE3, 3'h0, 2'b11, 16'hFFFF, 16'hB6C3);
      run(8'hE3, 3'h1, 2'b01, 16'h0000, 16'h0000);
      run(8'hE5, 3'h6, 2'b01, 16'h0000, 16'h0000);
      run(8'hE5, 3'h7, 2'b01, 16'h0000, 16'h0000);
      run(8'hE6, 3'h0, 2'b11, 16'hFFFF, 16'hB6C3);
      run(8'hE7, 3'h0, 2'b00, 16'h0000, 16'h0000);
      $display("t_ide done");
   endtask : t_ide
   task automatic t_mode;
      i_host.mode_pin(1'b1);
      repeat (6) @(negedge clk);
      `CHK(ide_mode, 1'b0)
      i_host.mode_pin(1'b0);
      repeat (LOWC / 2) @(negedge clk);
      `CHK(ide_mode, 1'b0)
      repeat (LOWC / 2 + 10) @(negedge clk);
      `CHK(ide_mode, 1'b1)
      $display("t_mode done");
   endtask : t_mode
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   initial
   begin
      #20000;
      err_count++;
      $display("Watchdog expired");
      complete_run;
   end
   initial
   begin
      reset = 1'b1;
      stall = 1'b0;
      core_ready = 1'b1;
      core_rdata_valid = 1'b0;
      rcnt = 0;
      err_count = 0;
      checks = 0;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      t_pc;
      t_write;
      t_buf;
      t_ide;
      t_mode;
      complete_run;
   end
endmodule : card_host_transfer_decode_tb
